// *** design/ts_status_pkg.sv ***
// constants, types and register map for the transport-stream status and flow register bank
// ****************************************
// Operation
// - interrupt flags in bits 8 to 12 set on their event and stay set.
// - writing one to a flag clears it; interrupt drops unless another enabled flag pends.
// - a flag raises the interrupt only with its enable and bridge enable set.
// - flags latch their events even while their enable is zero.
// - status holds fill flag bit 0, capacity 7:4, flags 12:8, zero above.
// - fill flag is one when byte count reaches fill limit; DMA requests then withheld.
// - capacity code is constant: 0000 8 MB, 0001 16 MB, 0010 32 MB.
// - periodic tick flag sets every two to the 21st reference clock cycles.
// - underrun flag sets when the buffer runs empty during transmission.
// - alignment error sets when 0x47 spacing differs from 188, 192 or 204.
// - alignment checked only in run state, not unframed; bytes dropped until realigned.
// - short flag latches on any output short, cleared only by writing one.
// - comparator flag sets when either threshold comparator output changes.
// - byte clock equals 27 times 32-bit increment over two to the 32nd MHz.
// - with external clock select zero the rate generator paces output bytes.
// - increments above 80000000h are accepted with no error or interrupt.
// - 32-bit counter counts every external clock rising edge, readable any time.
// - 24-bit fill limit demands DMA below it, re-enables once count drops below.
// - fill limit does not affect directly written buffer data.
// - byte count reports buffered bytes in 24 bits, upper bits zero.
// - at memory size plus 256 bytes further writes are dropped, count held.
// - diagnostics bits 7:0 show buffer head byte; soft reset clears the register.
// - transmit state code 11 is the run state that sends packets.
// ****************************************
package ts_status_pkg;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RATE = 8'h0c;
	localparam logic [7:0] OFS_EDGE = 8'h10;
	localparam logic [7:0] OFS_LIMIT = 8'h14;
	localparam logic [7:0] OFS_COUNT = 8'h18;
	localparam logic [7:0] OFS_DIAG = 8'h1c;

	localparam int FILL_POS = 0;
	localparam int CAP_POS = 4;
	localparam int FLAG_POS = 8;
	localparam int NUM_FLAGS = 5;
	localparam int COUNT_W = 24;

	localparam logic [3:0] CAP_8MB = 4'h0;
	localparam logic [3:0] CAP_16MB = 4'h1;
	localparam logic [3:0] CAP_32MB = 4'h2;
	localparam int MEM_BYTES_8MB = 8388608;
	localparam int OVERSHOOT_BYTES = 256;

	localparam logic [31:0] RATE_RESET = 32'h0000_0000;
	localparam logic [23:0] LIMIT_RESET = 24'h00_0000;

	localparam int REF_MHZ = 27;
	localparam int SYS_MHZ = 200;
	localparam logic [31:0] REF_STEP = 32'((64'(REF_MHZ) << 32) / 64'(SYS_MHZ));
	localparam int TICK_LOG2 = 21;

	localparam logic [7:0] SYNC_BYTE = 8'h47;
	localparam logic [7:0] LEN_188 = 8'hbc;
	localparam logic [7:0] LEN_192 = 8'hc0;
	localparam logic [7:0] LEN_204 = 8'hcc;

	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_HOLD = 2'h1, ST_RSVD = 2'h2, ST_SEND = 2'h3} transmit_state_t;
	typedef enum logic [2:0] {MODE_188, MODE_192, MODE_204, MODE_APPEND_SIXTEEN_MODE, MODE_DROP_SIXTEEN_MODE, MODE_RAW} pkt_mode_t;

	// flag order matches status bits 8..12
	typedef struct packed {
		logic comparator_change;
		logic output_short;
		logic alignment_error;
		logic underrun;
		logic periodic_tick;
	} int_flags_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_t;
endpackage

// *** design/ts_byte_fifo.sv ***
// small byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module ts_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic push;
	logic pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem[rd_ptr_ff];
	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_in_data;
		end
	end

	// full and empty are registered so the ready seen by the source is a clean flop
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || i_flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= nxt_count;
			o_in_ready <= nxt_count != (AW+1)'(DEPTH);
			o_out_valid <= nxt_count != '0;
		end
	end
endmodule // ts_byte_fifo

// *** design/ts_output_status_flow_regs.sv ***
// status, rate generator, flow-control and diagnostics registers of the stream output
`timescale 1ns/1ps
module ts_output_status_flow_regs import ts_status_pkg::*; #(
	parameter int TICK_BITS = TICK_LOG2,
	parameter int MEM_BYTES = MEM_BYTES_8MB,
	parameter logic [3:0] CAPACITY_CODE = CAP_8MB,
	parameter int BUF_DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire reg_req_t i_reg_req,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic [4:0] i_int_enable,
	input wire logic i_bridge_int_en,
	input wire transmit_state_t i_transmit_state,
	input wire pkt_mode_t i_packet_mode,
	input wire logic i_external_clock_select,
	input wire logic i_soft_reset,
	input wire logic i_clear_buffer,
	input wire logic i_output_short_live,
	input wire logic i_comparator_a,
	input wire logic i_comparator_b,
	input wire logic i_ext_clk,
	input wire logic i_wr_valid,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_is_dma,
	output logic o_wr_ready,
	output logic o_dma_req,
	output logic o_host_irq,
	output logic o_byte_strobe,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data
);
	localparam logic [COUNT_W-1:0] CAP_LIMIT = COUNT_W'(MEM_BYTES + OVERSHOOT_BYTES);

	// ****************************************
	// register decode
	// ****************************************
	function automatic logic hit(input reg_req_t req, input logic [7:0] ofs);
		hit = req.wr && (req.addr == ofs);
	endfunction

	int_flags_t flags_ff;
	int_flags_t events;
	int_flags_t clears;
	logic [31:0] rate_phase_increment_ff;
	logic [23:0] dma_fill_limit_ff;
	logic [31:0] external_edge_counter_ff;
	logic [COUNT_W-1:0] buffer_byte_count_ff;
	logic [7:0] diag_ff;
	logic buffer_limit_reached;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rate_phase_increment_ff <= RATE_RESET;
		end else if (hit(i_reg_req, OFS_RATE)) begin
			rate_phase_increment_ff <= i_reg_req.wdata;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			dma_fill_limit_ff <= LIMIT_RESET;
		end else if (hit(i_reg_req, OFS_LIMIT)) begin
			dma_fill_limit_ff <= i_reg_req.wdata[23:0];
		end
	end

	// ****************************************
	// rate generation
	// ****************************************
	logic [31:0] ref_acc_ff;
	logic ref_tick_ff;
	logic [31:0] rate_acc_ff;
	logic rate_carry_ff;
	logic ext_prev_ff;
	logic ext_rise;

	// fractional divider gives the 27 MHz reference as an enable at the system rate
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ref_acc_ff <= '0;
			ref_tick_ff <= 1'b0;
		end else begin
			{ref_tick_ff, ref_acc_ff} <= {1'b0, ref_acc_ff} + {1'b0, REF_STEP};
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rate_acc_ff <= '0;
			rate_carry_ff <= 1'b0;
		end else if (ref_tick_ff) begin
			{rate_carry_ff, rate_acc_ff} <= {1'b0, rate_acc_ff} + {1'b0, rate_phase_increment_ff};
		end else begin
			rate_carry_ff <= 1'b0;
		end
	end

	assign ext_rise = i_ext_clk && !ext_prev_ff;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ext_prev_ff <= 1'b0;
			external_edge_counter_ff <= '0;
		end else begin
			ext_prev_ff <= i_ext_clk;
			if (ext_rise) begin
				external_edge_counter_ff <= external_edge_counter_ff + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_byte_strobe <= 1'b0;
		end else begin
			o_byte_strobe <= i_external_clock_select ? ext_rise : rate_carry_ff;
		end
	end

	// ****************************************
	// periodic tick
	// ****************************************
	logic [TICK_BITS-1:0] tick_cnt_ff;
	logic tick_event;

	assign tick_event = ref_tick_ff && (tick_cnt_ff == '1);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			tick_cnt_ff <= '0;
		end else if (ref_tick_ff) begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	// ****************************************
	// buffer and transmit path
	// ****************************************
	logic at_cap;
	logic push_ok;
	logic fifo_ready;
	logic fifo_valid;
	logic [7:0] smoothing_buffer_head;
	logic sending;
	logic pop;
	logic framed;
	logic locked_ff;
	logic [7:0] pos_ff;
	logic [7:0] pkt_len;
	logic emit;
	logic sync_err;

	assign at_cap = buffer_byte_count_ff >= CAP_LIMIT;
	// buffer at the capacity limit drops the write but still completes the handshake
	assign push_ok = i_wr_valid && fifo_ready && !at_cap;
	assign o_wr_ready = fifo_ready;
	assign sending = i_transmit_state == ST_SEND;
	assign pop = o_byte_strobe && sending && fifo_valid;
	assign framed = i_packet_mode != MODE_RAW;

	ts_byte_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_flush(i_clear_buffer),
		.i_in_valid(i_wr_valid && !at_cap),
		.i_in_data(i_wr_data),
		.o_in_ready(fifo_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(smoothing_buffer_head),
		.i_out_ready(pop)
	);

	always_comb begin
		unique case (i_packet_mode)
			MODE_192: pkt_len = LEN_192;
			MODE_204, MODE_DROP_SIXTEEN_MODE: pkt_len = LEN_204;
			default: pkt_len = LEN_188;
		endcase
	end

	// while unlocked, bytes are dropped until a sync byte restarts the packet
	always_comb begin
		emit = 1'b0;
		sync_err = 1'b0;
		if (pop) begin
			if (!framed) begin
				emit = 1'b1;
			end else if (locked_ff) begin
				sync_err = (pos_ff == 8'h00) && (smoothing_buffer_head != SYNC_BYTE);
				emit = !sync_err;
			end else begin
				emit = smoothing_buffer_head == SYNC_BYTE;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !framed) begin
			locked_ff <= 1'b1;
			pos_ff <= '0;
		end else if (sync_err) begin
			locked_ff <= 1'b0;
		end else if (emit) begin
			locked_ff <= 1'b1;
			pos_ff <= (pos_ff == pkt_len - 8'h01) ? 8'h00 : pos_ff + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_tx_valid <= 1'b0;
			o_tx_data <= '0;
		end else begin
			o_tx_valid <= emit;
			if (emit) begin
				o_tx_data <= smoothing_buffer_head;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || i_clear_buffer) begin
			buffer_byte_count_ff <= '0;
		end else begin
			buffer_byte_count_ff <= buffer_byte_count_ff + COUNT_W'(push_ok) - COUNT_W'(pop);
		end
	end

	// direct writes are paced only by ready, never by the limit
	assign buffer_limit_reached = buffer_byte_count_ff >= dma_fill_limit_ff;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_dma_req <= 1'b0;
		end else begin
			o_dma_req <= (i_transmit_state != ST_IDLE) && !buffer_limit_reached;
		end
	end

	// ****************************************
	// interrupt flags
	// ****************************************
	logic cmp_a_prev_ff;
	logic cmp_b_prev_ff;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cmp_a_prev_ff <= 1'b0;
			cmp_b_prev_ff <= 1'b0;
		end else begin
			cmp_a_prev_ff <= i_comparator_a;
			cmp_b_prev_ff <= i_comparator_b;
		end
	end

	always_comb begin
		events.periodic_tick = tick_event;
		events.underrun = o_byte_strobe && sending && !fifo_valid;
		events.alignment_error = sync_err;
		events.output_short = i_output_short_live;
		events.comparator_change = (i_comparator_a != cmp_a_prev_ff) || (i_comparator_b != cmp_b_prev_ff);
		clears = hit(i_reg_req, OFS_STATUS) ? int_flags_t'(i_reg_req.wdata[FLAG_POS +: NUM_FLAGS]) : '0;
	end

	// a new event in the clearing cycle wins, independent of enables
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~clears) | events;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_host_irq <= 1'b0;
		end else begin
			o_host_irq <= i_bridge_int_en && |(flags_ff & i_int_enable);
		end
	end

	// ****************************************
	// diagnostics and read-back
	// ****************************************
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || i_soft_reset) begin
			diag_ff <= '0;
		end else begin
			diag_ff <= smoothing_buffer_head;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= '0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_req.rd;
			o_reg_rdata <= '0;
			if (i_reg_req.rd) begin
				unique case (i_reg_req.addr)
					OFS_STATUS: o_reg_rdata <= {19'h0_0000, flags_ff, CAPACITY_CODE, 3'h0, buffer_limit_reached};
					OFS_RATE: o_reg_rdata <= rate_phase_increment_ff;
					OFS_EDGE: o_reg_rdata <= external_edge_counter_ff;
					OFS_LIMIT: o_reg_rdata <= {8'h00, dma_fill_limit_ff};
					OFS_COUNT: o_reg_rdata <= {8'h00, buffer_byte_count_ff};
					OFS_DIAG: o_reg_rdata <= {24'h00_0000, diag_ff};
					default: o_reg_rdata <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	a_flags_sticky: assert property (flags_ff.underrun && !clears.underrun |=> flags_ff.underrun)
		else $error("underrun flag dropped without clear");
	a_clear_flag: assert property (clears.periodic_tick && !events.periodic_tick |=> !flags_ff.periodic_tick)
		else $error("write one did not clear tick flag");
	a_irq_gating: assert property (##1 o_host_irq == $past(i_bridge_int_en && |(flags_ff & i_int_enable)))
		else $error("interrupt output not gated by enables");
	a_latch_no_enable: assert property (events.output_short && !i_int_enable[3] |=> flags_ff.output_short)
		else $error("short flag not latched while disabled");
	a_status_layout: assert property (i_reg_req.rd && i_reg_req.addr == OFS_STATUS |=>
		o_reg_rdata[31:13] == '0 && o_reg_rdata[3:1] == '0 && o_reg_rdata[7:4] == CAPACITY_CODE)
		else $error("status layout wrong");
	a_dma_withheld: assert property (buffer_limit_reached |=> !o_dma_req)
		else $error("dma requested at fill limit");
	a_underrun_set: assert property (o_byte_strobe && sending && !fifo_valid |=> flags_ff.underrun)
		else $error("underrun not flagged");
	a_sync_discard: assert property (sync_err |=> flags_ff.alignment_error && !o_tx_valid)
		else $error("alignment error not handled");
	a_raw_unchecked: assert property (!framed |-> !sync_err)
		else $error("alignment checked in raw mode");
	a_edge_count: assert property (ext_rise |=> external_edge_counter_ff == $past(external_edge_counter_ff) + 32'h0000_0001)
		else $error("external edge not counted");
	a_cap_hold: assert property (at_cap && !pop && !i_clear_buffer |=> buffer_byte_count_ff == $past(buffer_byte_count_ff))
		else $error("count grew past cap");
	a_diag_clear: assert property (i_soft_reset |=> diag_ff == 8'h00)
		else $error("soft reset left diagnostics");
	a_idle_quiet: assert property (!sending |=> !o_tx_valid)
		else $error("byte sent outside run state");

	// pacing, flow and flag checks
	a_strobe_source: assert property (!i_external_clock_select && !rate_carry_ff |=>
		!o_byte_strobe)
		else $error("byte strobe without internal rate carry");
	a_tick_flag: assert property (tick_event |=> flags_ff.periodic_tick)
		else $error("periodic tick not flagged");
	a_dma_resume: assert property (i_transmit_state != ST_IDLE && !buffer_limit_reached |=>
		o_dma_req)
		else $error("dma not demanded below fill limit");
	a_limit_write: assert property (hit(i_reg_req, OFS_LIMIT) |=>
		dma_fill_limit_ff == $past(i_reg_req.wdata[23:0]))
		else $error("fill limit write lost");
	a_short_sticky: assert property (flags_ff.output_short && !clears.output_short |=>
		flags_ff.output_short)
		else $error("short flag dropped without clear");
	a_raw_passthru: assert property (pop && !framed |=>
		o_tx_valid && o_tx_data == $past(smoothing_buffer_head))
		else $error("raw byte not passed through");
	a_edge_hold: assert property (!ext_rise |=>
		external_edge_counter_ff == $past(external_edge_counter_ff))
		else $error("edge counter moved without an edge");

	// read-back checks look one cycle back at the request that produced the data
	a_fill_read: assert property (i_reg_req.rd && i_reg_req.addr == OFS_STATUS |=>
		o_reg_rdata[FILL_POS] == $past(buffer_limit_reached))
		else $error("fill flag read back wrong");
	a_count_upper: assert property (i_reg_req.rd && i_reg_req.addr == OFS_COUNT |=>
		o_reg_rdata[31:24] == 8'h00)
		else $error("byte count upper bits not zero");
	a_diag_upper: assert property (i_reg_req.rd && i_reg_req.addr == OFS_DIAG |=>
		o_reg_rdata[31:8] == 24'h00_0000)
		else $error("diagnostics upper bits not zero");

	c_tick_irq: cover property (flags_ff.periodic_tick && o_host_irq);
	c_resync: cover property (sync_err ##[1:400] emit);
	c_fill_reached: cover property (!buffer_limit_reached ##1 buffer_limit_reached);
	c_clear_race: cover property (clears.comparator_change && events.comparator_change);
	c_underrun: cover property (events.underrun ##1 flags_ff.underrun);
endmodule // ts_output_status_flow_regs

// *** bench/ts_dma_feeder.sv ***
// byte source standing in for the host bridge, writing directly or paced by the dma request
`timescale 1ns/1ps
module ts_dma_feeder #(
	parameter int GAP = 2
) (
	input wire logic i_sys_clk,
	input wire logic i_enable,
	input wire logic i_use_dma,
	input wire logic i_dma_req,
	input wire logic i_wr_ready,
	input wire logic [7:0] i_first,
	input wire logic [7:0] i_count,
	output logic o_wr_valid = 1'b0,
	output logic [7:0] o_wr_data = 8'h00
);
	// ****************************************
	// write sequencer
	// ****************************************
	logic [7:0] sent_ff;
	logic [1:0] gap_ff;
	// the gap lets the registered request catch up, so the load cannot overshoot the limit
	always @(posedge i_sys_clk) begin
		if (!i_enable) begin
			sent_ff <= 8'h00;
			gap_ff <= 2'h0;
			o_wr_valid <= 1'b0;
		end else if (o_wr_valid) begin
			if (i_wr_ready) begin
				o_wr_valid <= 1'b0;
				o_wr_data <= ~o_wr_data; // released data must never look like the last byte
				sent_ff <= sent_ff + 8'h01;
				gap_ff <= 2'(GAP);
			end
		end else if (gap_ff != 2'h0) begin
			gap_ff <= gap_ff - 2'h1;
		end else if (sent_ff < i_count && (!i_use_dma || i_dma_req)) begin
			o_wr_valid <= 1'b1;
			o_wr_data <= (sent_ff == 8'h00) ? i_first : sent_ff;
		end
	end
endmodule // ts_dma_feeder

// *** bench/ts_output_status_flow_regs_tb.sv ***
// self-checking bench for the status, rate and flow-control register bank
`timescale 1ns/1ps
module ts_output_status_flow_regs_tb import ts_status_pkg::*; ;
	// ****************************************
	// signals and instances
	// ****************************************
	logic clk, rvalid, wr_valid, wr_ready, dma_req, irq, tx_valid, strobe;
	logic rst_n = 1'b0, bridge_en = 1'b0, ext_sel = 1'b0, soft_rst = 1'b0, clr_buf = 1'b0;
	logic short_live = 1'b0, cmp_a = 1'b0, cmp_b = 1'b0, ext_clk = 1'b0, f_en = 1'b0, f_dma = 1'b0;
	logic [7:0] wr_data, tx_data;
	logic [7:0] f_first = 8'h00, f_cnt = 8'h00;
	logic [4:0] int_en = 5'h00;
	logic [31:0] rdata, d;
	reg_req_t req = '0;
	transmit_state_t tstate = ST_IDLE;
	pkt_mode_t pmode = MODE_188;
	int failures = 0, checks = 0, cycles = 0, strobes = 0, s0 = 0;
	logic [7:0] tx_q[$];
	logic [7:0] exp_tx[8] = '{8'h47, 8'h01, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03, 8'h04};

	ts_output_status_flow_regs #(.TICK_BITS(4), .CAPACITY_CODE(CAP_16MB)) u_dut (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_int_enable(int_en), .i_bridge_int_en(bridge_en), .i_transmit_state(tstate), .i_packet_mode(pmode),
		.i_external_clock_select(ext_sel), .i_soft_reset(soft_rst), .i_clear_buffer(clr_buf),
		.i_output_short_live(short_live), .i_comparator_a(cmp_a), .i_comparator_b(cmp_b), .i_ext_clk(ext_clk),
		.i_wr_valid(wr_valid), .i_wr_data(wr_data), .i_wr_is_dma(f_dma), .o_wr_ready(wr_ready),
		.o_dma_req(dma_req), .o_host_irq(irq), .o_byte_strobe(strobe), .o_tx_valid(tx_valid), .o_tx_data(tx_data)
	);
	ts_dma_feeder #(.GAP(2)) u_feeder (
		.i_sys_clk(clk), .i_enable(f_en), .i_use_dma(f_dma), .i_dma_req(dma_req), .i_wr_ready(wr_ready),
		.i_first(f_first), .i_count(f_cnt), .o_wr_valid(wr_valid), .o_wr_data(wr_data)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		cyc(1);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		cyc(1);
		req.wr = 1'b0;
	endtask
	// a missing answer turns into unknown data, so the compare of that read fails
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		cyc(1);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		cyc(1);
		req.rd = 1'b0;
		d = (rvalid === 1'b1) ? rdata : 'x;
		chk(d & m, e);
	endtask
	task automatic reset_dut();
		f_en = 1'b0;
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		tx_q.delete();
	endtask
	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask
	task automatic close_out();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		if (tx_valid === 1'b1) tx_q.push_back(tx_data);
		if (strobe === 1'b1) strobes++;
		cycles++;
		if (cycles == 8000) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
			close_out();
		end
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		reset_dut();
		rdchk(OFS_STATUS, 32'hffff_feff, (32'(CAP_16MB) << CAP_POS) | 32'h1);
		rdchk(8'h04, 32'hffff_ffff, 32'h0);
		wr(OFS_STATUS, 32'hffff_e0fe);
		rdchk(OFS_STATUS, 32'hffff_feff, (32'(CAP_16MB) << CAP_POS) | 32'h1);
		wr(OFS_RATE, 32'h8000_0001);
		rdchk(OFS_RATE, 32'hffff_ffff, 32'h8000_0001);
		wr(OFS_LIMIT, 32'hff00_0003);
		rdchk(OFS_LIMIT, 32'hffff_ffff, 32'h0000_0003);
		rdchk(OFS_STATUS, 32'h1, 32'h0);
		chk(32'(irq), 32'h0);
		repeat (6) begin
			cyc(3);
			ext_clk = 1'b1;
			cyc(3);
			ext_clk = 1'b0;
		end
		cyc(3);
		rdchk(OFS_EDGE, 32'hffff_ffff, 32'h6);
		tdone("registers");
		cmp_a = 1'b1;
		int_en = 5'h08;
		cyc(3);
		rdchk(OFS_STATUS, 32'h1800, 32'h1000);
		bridge_en = 1'b1;
		cyc(3);
		chk(32'(irq), 32'h0);
		short_live = 1'b1;
		cyc(1);
		short_live = 1'b0;
		cyc(3);
		chk(32'(irq), 32'h1);
		int_en = 5'h18;
		wr(OFS_STATUS, 32'h0000_1000);
		rdchk(OFS_STATUS, 32'h1800, 32'h0800);
		chk(32'(irq), 32'h1);
		wr(OFS_STATUS, 32'h0000_0800);
		cyc(2);
		chk(32'(irq), 32'h0);
		rdchk(OFS_STATUS, 32'h1800, 32'h0);
		int_en = 5'h00;
		wr(OFS_STATUS, 32'h0000_0100);
		cyc(125);
		rdchk(OFS_STATUS, 32'h0100, 32'h0100);
		tdone("interrupt flags");
		tstate = ST_HOLD;
		f_dma = 1'b1;
		f_first = SYNC_BYTE;
		f_cnt = 8'h08;
		f_en = 1'b1;
		cyc(40);
		rdchk(OFS_COUNT, 32'hffff_ffff, 32'h3);
		chk(32'(dma_req), 32'h0);
		rdchk(OFS_STATUS, 32'h1, 32'h1);
		f_en = 1'b0;
		cyc(1);
		f_dma = 1'b0;
		f_first = 8'h03;
		f_cnt = 8'h05;
		f_en = 1'b1;
		cyc(40);
		rdchk(OFS_COUNT, 32'hffff_ffff, 32'h8);
		chk(32'(wr_ready), 32'h0);
		rdchk(OFS_DIAG, 32'hff, 32'(SYNC_BYTE));
		soft_rst = 1'b1;
		rdchk(OFS_DIAG, 32'hffff_ffff, 32'h0);
		soft_rst = 1'b0;
		tdone("flow control");
		wr(OFS_RATE, 32'h8000_0000);
		tstate = ST_SEND;
		cyc(2);
		s0 = strobes;
		cyc(250);
		chk(32'((strobes - s0) inside {[16:17]}), 32'h1);
		chk(32'(tx_q.size()), 32'h8);
		foreach (exp_tx[i]) chk(32'(tx_q[i]), 32'(exp_tx[i]));
		rdchk(OFS_COUNT, 32'hffff_ffff, 32'h0);
		rdchk(OFS_STATUS, 32'h0600, 32'h0200);
		tdone("transmit");
		reset_dut();
		wr(OFS_RATE, 32'h8000_0000);
		pmode = MODE_RAW;
		ext_sel = 1'b1;
		f_first = 8'h00;
		f_cnt = 8'h01;
		f_en = 1'b1;
		s0 = strobes;
		cyc(60);
		chk(32'(tx_q.size()), 32'h0);
		chk(32'(strobes - s0), 32'h0);
		ext_clk = 1'b1;
		cyc(8);
		ext_clk = 1'b0;
		chk(32'(strobes - s0), 32'h1);
		chk(32'(tx_q.size()), 32'h1);
		chk(32'(tx_q[0]), 32'h0);
		rdchk(OFS_STATUS, 32'h0400, 32'h0);
		tdone("raw external clock");
		reset_dut();
		wr(OFS_RATE, 32'h8000_0000);
		pmode = MODE_188;
		ext_sel = 1'b0;
		f_cnt = 8'h02;
		f_en = 1'b1;
		cyc(80);
		rdchk(OFS_STATUS, 32'h0400, 32'h0400);
		chk(32'(tx_q.size()), 32'h0);
		f_en = 1'b0;
		cyc(1);
		f_first = SYNC_BYTE;
		f_cnt = 8'h01;
		f_en = 1'b1;
		cyc(40);
		chk(32'(tx_q.size()), 32'h1);
		chk(32'(tx_q[0]), 32'(SYNC_BYTE));
		tdone("alignment");
		// 193 bytes: a 192 packet then a stray byte at the next packet start, or one long 204 packet
		for (int k = 0; k < 2; k++) begin
			reset_dut();
			wr(OFS_RATE, 32'hffff_ffff);
			pmode = (k == 0) ? MODE_192 : MODE_204;
			f_first = SYNC_BYTE;
			f_cnt = 8'hc1;
			f_en = 1'b1;
			cyc(1600);
			chk(32'(tx_q.size()), (k == 0) ? 32'hc0 : 32'hc1);
			rdchk(OFS_STATUS, 32'h0400, (k == 0) ? 32'h0400 : 32'h0);
		end
		tdone("packet lengths");
		close_out();
	end
endmodule // ts_output_status_flow_regs_tb
